// *** logic/hrxds_pkg.sv ***
// Constants and carrier types for the receive descriptor status write-back block.
// Assumes one receive channel fed by an octet stream from the serial side.
// Summary of operation
// - Interrupt bit clear: no buffer-used event
// - Interrupt bit set: raise buffer event; frame event on every HDLC frame end
// - HDLC: set last bit on frame end
// - Error end sets at least one error bit
// - Last buffer length equals total frame octets
// - First bit set only on frame start buffer
// - Continuous mode keeps empty bit set
// - Continuous mode keeps empty even on error
// - Never alter the user bit
// - Oversize: set violation, store rounded maximum
// - Detect oversize at longword write, three bytes
// - After oversize discard until closing flag
// - Oversize length counts all octets received
// - Never reuse a descriptor while not empty
// - After wrap descriptor return to ring start
// - Write length exactly once at close
package hrxds_pkg;
   localparam int DESC_BITS      = 32;
   localparam int BIT_EMPTY      = 0;
   localparam int BIT_WRAP       = 2;
   localparam int BIT_INTR       = 3;
   localparam int BIT_LAST       = 4;
   localparam int BIT_FIRST      = 5;
   localparam int BIT_CONT       = 6;
   localparam int BIT_SWFLAG     = 8;
   localparam int BIT_OVERSIZE   = 10;
   localparam int BIT_ABORT      = 12;
   localparam int BIT_OVERRUN    = 14;
   localparam int BIT_CARRIER    = 15;
   localparam int LEN_LSB        = 16;
   localparam int LEN_BITS       = 16;
   localparam int IDX_BITS       = 4;
   localparam int LONG_BYTES     = 4;
   localparam logic [15:0] STATUS_KEEP = 16'h014f; // E,bit 1,W,I,CM,software flag kept
   localparam logic [IDX_BITS-1:0] RING_RESET = 4'h0;

   // Octet arriving from the serial side
   typedef struct packed {
      logic [7:0] data;
      logic       frame_start;
      logic       frame_end;
      logic       abort_seen;
      logic       carrier_lost;
      logic       overrun;
   } hrxds_octet_type;

   // Descriptor write-back towards shared memory
   typedef struct packed {
      logic [IDX_BITS-1:0]   index;
      logic [DESC_BITS-1:0]  word;
   } hrxds_wb_type;
endpackage

// *** logic/hrxds_skid.sv ***
// Two-entry buffer between the serial octet stream and the status logic.
// Assumes both sides run on ref_clk.
module hrxds_skid #(
   parameter int WIDTH = 13
) (
   input  wire logic             ref_clk,   // System clock
   input  wire logic             reset,     // Async reset, high
   input  wire logic [WIDTH-1:0] in_data,   // Filling side data
   input  wire logic             in_valid,  // Filling side valid
   output      logic             in_ready,  // Room available
   output      logic [WIDTH-1:0] out_data,  // Draining side data
   output      logic             out_valid, // Entry present
   input  wire logic             out_ready  // Drain accepts
);
   logic [WIDTH-1:0] mem_q [2];
   logic             wp_q, rp_q;
   logic [1:0]       cnt_q;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   // Honest full and empty flags
   assign in_ready  = cnt_q != 2'h2;
   assign out_valid = cnt_q != 2'h0;
   assign out_data  = mem_q[rp_q];

   // Pointer and occupancy update
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wp_q  <= 1'b0;
         rp_q  <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (push) wp_q <= ~wp_q;
         if (pop) rp_q <= ~rp_q;
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end

   // Entry storage
   always_ff @(posedge ref_clk) begin
      if (push) mem_q[wp_q] <= in_data;
   end
endmodule // hrxds_skid

// *** logic/hrxds_status.sv ***
// Receive descriptor status write-back for one HDLC or transparent channel.
// Assumes the descriptor word arrives on desc_rd when desc_valid is high and
// that software owns the descriptor while its empty bit is clear.
module hrxds_status #(
   parameter int BUF_BYTES = 64 // Buffer size in octets before close
) (
   input  wire logic                               ref_clk,      // System clock
   input  wire logic                               reset,        // Async reset, high
   input  wire logic                               hdlc_mode,    // 1 HDLC, 0 transparent
   input  wire logic [15:0]                        max_frame_length, // Frame limit
   input  wire hrxds_pkg::hrxds_octet_type         octet,        // Octet from serial side
   input  wire logic                               octet_valid,  // Octet present
   output      logic                               octet_ready,  // Buffer has room
   input  wire logic [hrxds_pkg::DESC_BITS-1:0]    desc_rd,      // Current descriptor
   input  wire logic                               desc_valid,   // desc_rd is current
   output      logic [hrxds_pkg::IDX_BITS-1:0]     desc_index,   // Descriptor in use
   output      hrxds_pkg::hrxds_wb_type            wb,           // Close write-back
   output      logic                               wb_valid,     // Write-back pulse
   output      logic                               buffer_used_event,    // Pulse
   output      logic                               frame_received_event, // Pulse
   output      logic                               octet_store   // Octet kept, pulse
);
   localparam logic [15:0] ONE = 16'h0001;
   hrxds_pkg::hrxds_octet_type cur;
   logic        cur_valid;
   logic [15:0] frame_cnt_q, buf_cnt_q, buf_cnt_d;
   logic        in_frame_q, started_q, oversize_q, first_q;
   logic [hrxds_pkg::IDX_BITS-1:0] idx_q;
   logic [hrxds_pkg::DESC_BITS-1:0] wb_word_q;
   logic        wb_q, bu_q, fr_q, store_q;
   logic        take;                                // Octet consumed this cycle
   logic [hrxds_pkg::IDX_BITS-1:0] wb_idx_q;         // Index of the closed descriptor

   // Two-entry buffer in the octet path
   hrxds_skid #(.WIDTH($bits(hrxds_pkg::hrxds_octet_type))) u_skid (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .in_data   (octet),
      .in_valid  (octet_valid),
      .in_ready  (octet_ready),
      .out_data  (cur),
      .out_valid (cur_valid),
      .out_ready (take)
   );

   // Stall while descriptor not owned or write-back in flight
   wire owned = desc_valid && desc_rd[hrxds_pkg::BIT_EMPTY];
   assign take = cur_valid && owned && !wb_q;
   wire fstart = take && cur.frame_start;
   wire [15:0] fcount = fstart ? ONE : frame_cnt_q + ONE;
   // Limit rounded up to a longword boundary
   wire [15:0] round_max = (max_frame_length + 16'h0003) & 16'hfffc;
   // Exceeded when the next longword write would pass the limit
   wire over_now = hdlc_mode && (fcount > round_max);
   wire ovs    = oversize_q && !fstart;
   wire keep   = take && !(ovs || over_now);
   wire err    = cur.abort_seen || cur.carrier_lost || cur.overrun;
   wire fend   = take && hdlc_mode && (cur.frame_end || err);
   wire bfull  = keep && (buf_cnt_d == 16'(BUF_BYTES));
   wire close  = fend || (take && bfull);
   wire lastb  = fend;
   wire viol   = ovs || over_now;
   wire intr   = desc_rd[hrxds_pkg::BIT_INTR];
   wire cont   = desc_rd[hrxds_pkg::BIT_CONT];
   // A buffer is first when its opening octet starts a frame; only HDLC has frames
   wire opens   = fstart || (hdlc_mode && !in_frame_q);
   wire isfirst = started_q ? first_q : opens;
   wire [15:0] len = lastb ? fcount : buf_cnt_d;
   assign buf_cnt_d = keep ? buf_cnt_q + ONE : buf_cnt_q;

   // Status half of the closed descriptor
   wire [15:0] keep_bits = desc_rd[15:0] & hrxds_pkg::STATUS_KEEP;
   wire [15:0] stat = {keep_bits[15:1], ~cont ? 1'b0 : keep_bits[0]}
      | (16'(lastb && hdlc_mode) << hrxds_pkg::BIT_LAST)
      | (16'(isfirst) << hrxds_pkg::BIT_FIRST)
      | (16'(lastb && viol && hdlc_mode) << hrxds_pkg::BIT_OVERSIZE)
      | (16'(fend && cur.abort_seen) << hrxds_pkg::BIT_ABORT)
      | (16'(fend && cur.overrun) << hrxds_pkg::BIT_OVERRUN)
      | (16'(fend && cur.carrier_lost) << hrxds_pkg::BIT_CARRIER);

   // Ring index after close, wrapping to start
   wire [hrxds_pkg::IDX_BITS-1:0] idx_next = desc_rd[hrxds_pkg::BIT_WRAP] ?
      hrxds_pkg::RING_RESET : idx_q + 4'h1;

   // Frame, buffer and ring state
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         frame_cnt_q <= 16'h0000;
         buf_cnt_q   <= 16'h0000;
         in_frame_q  <= 1'b0;
         started_q   <= 1'b0;
         oversize_q  <= 1'b0;
         first_q     <= 1'b0;
         idx_q       <= hrxds_pkg::RING_RESET;
      end else if (take) begin
         frame_cnt_q <= fend ? 16'h0000 : fcount;
         oversize_q  <= fend ? 1'b0 : viol;
         in_frame_q  <= !fend;
         if (close) begin
            buf_cnt_q <= 16'h0000;
            started_q <= 1'b0;
            first_q   <= 1'b0;
            idx_q     <= idx_next;
         end else begin
            buf_cnt_q <= buf_cnt_d;
            started_q <= 1'b1;
            first_q   <= isfirst;
         end
      end
   end

   // Write-back word and event pulses, length written only on close
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wb_q      <= 1'b0;
         wb_word_q <= '0;
         wb_idx_q  <= hrxds_pkg::RING_RESET;
         bu_q      <= 1'b0;
         fr_q      <= 1'b0;
         store_q   <= 1'b0;
      end else begin
         wb_q    <= close;
         bu_q    <= close && intr;
         fr_q    <= close && lastb && hdlc_mode;
         store_q <= keep;
         if (close) wb_word_q <= {len, stat};
         if (close) wb_idx_q <= idx_q; // Ring index still names the closed descriptor
      end
   end

   assign desc_index           = idx_q;
   assign wb                   = '{index: wb_idx_q, word: wb_word_q};
   assign wb_valid             = wb_q;
   assign buffer_used_event    = bu_q;
   assign frame_received_event = fr_q;
   assign octet_store          = store_q;

   // Checks
   property p_no_event_without_intr;
      @(posedge ref_clk) disable iff (reset)
      (close && !intr) |=> !buffer_used_event;
   endproperty
   a_no_event_without_intr: assert property (p_no_event_without_intr)
      else $error("buffer event without interrupt bit");
   property p_event_with_intr;
      @(posedge ref_clk) disable iff (reset)
      (close && intr) |=> buffer_used_event && wb_valid;
   endproperty
   a_event_with_intr: assert property (p_event_with_intr)
      else $error("missing buffer event");
   property p_frame_event;
      @(posedge ref_clk) disable iff (reset)
      fend |=> frame_received_event && wb_valid;
   endproperty
   a_frame_event: assert property (p_frame_event)
      else $error("frame event missing at frame end");
   property p_swflag_kept;
      @(posedge ref_clk) disable iff (reset)
      close |=> wb.word[hrxds_pkg::BIT_SWFLAG] == $past(desc_rd[hrxds_pkg::BIT_SWFLAG]);
   endproperty
   a_swflag_kept: assert property (p_swflag_kept)
      else $error("software flag altered");
   property p_cont_empty;
      @(posedge ref_clk) disable iff (reset)
      (close && cont) |=> wb.word[hrxds_pkg::BIT_EMPTY];
   endproperty
   a_cont_empty: assert property (p_cont_empty)
      else $error("continuous mode cleared empty");
   property p_norm_empty;
      @(posedge ref_clk) disable iff (reset)
      (close && !cont) |=> !wb.word[hrxds_pkg::BIT_EMPTY];
   endproperty
   a_norm_empty: assert property (p_norm_empty)
      else $error("empty not cleared");
   property p_transparent_clear;
      @(posedge ref_clk) disable iff (reset)
      (close && !hdlc_mode) |=> !wb.word[hrxds_pkg::BIT_LAST]
         && !wb.word[hrxds_pkg::BIT_OVERSIZE];
   endproperty
   a_transparent_clear: assert property (p_transparent_clear)
      else $error("HDLC bit in transparent mode");
   property p_last_on_end;
      @(posedge ref_clk) disable iff (reset)
      fend |=> wb_valid && wb.word[hrxds_pkg::BIT_LAST];
   endproperty
   a_last_on_end: assert property (p_last_on_end)
      else $error("last bit missing");
   property p_once;
      @(posedge ref_clk) disable iff (reset)
      wb_valid |=> !wb_valid;
   endproperty
   a_once: assert property (p_once)
      else $error("length written twice");
   property p_no_take_unowned;
      @(posedge ref_clk) disable iff (reset)
      !owned |-> !take;
   endproperty
   a_no_take_unowned: assert property (p_no_take_unowned)
      else $error("descriptor used while not empty");
   property p_discard;
      @(posedge ref_clk) disable iff (reset)
      (take && ovs) |=> !octet_store;
   endproperty
   a_discard: assert property (p_discard)
      else $error("oversize data stored");
endmodule // hrxds_status

// *** verification/hrxds_host_model.sv ***
// Host-side model of the receive descriptor ring in shared memory.
// Assumes the status block reads the word at desc_index and writes back on wb_valid.
module hrxds_host_model (
   input  wire logic                            ref_clk,    // System clock
   input  wire logic                            reset,      // Async reset, high
   input  wire logic                            stall,      // Slow memory answer
   input  wire logic [hrxds_pkg::IDX_BITS-1:0]  desc_index, // Descriptor asked for
   input  wire hrxds_pkg::hrxds_wb_type         wb,         // Close write-back
   input  wire logic                            wb_valid,   // Write-back strobe
   output      logic [hrxds_pkg::DESC_BITS-1:0] desc_rd,    // Descriptor word
   output      logic                            desc_valid  // desc_rd is current
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [hrxds_pkg::DESC_BITS-1:0] mem [16];
   // Ring starts cleared, so nothing is owned by the block before arming
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 32'h0;
   end
   // Closed descriptors land back in memory as the block wrote them
   always @(posedge ref_clk) begin
      if (wb_valid === 1'b1) mem[wb.index] <= wb.word;
   end
   // A word that is not current shows inverted, so stale data never passes
   assign desc_valid = !stall && !reset;
   assign desc_rd    = desc_valid ? mem[desc_index] : ~mem[desc_index];
   // Software hands a descriptor over, or ends continuous mode by rewriting it
   task automatic arm(input int i, input logic [31:0] w);
      mem[i] = w;
   endtask
endmodule // hrxds_host_model

// *** verification/test_hrxds_status.sv ***
// Self-checking bench for the receive descriptor status block.
// Assumes the host model file is compiled first; random data from seed 18.
module test_hrxds_status;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BUF = 8;
   localparam int ERRB [4] = '{0, hrxds_pkg::BIT_ABORT, hrxds_pkg::BIT_CARRIER,
                               hrxds_pkg::BIT_OVERRUN};
   logic ref_clk = 1'b0, reset = 1'b1, hdlc_mode = 1'b1, octet_valid = 1'b0;
   logic stall = 1'b0, stall_en = 1'b0;
   logic [15:0] max_frame_length = 16'h0100;
   hrxds_pkg::hrxds_octet_type octet = '0;
   logic [31:0] desc_rd;
   logic desc_valid, octet_ready, wb_valid, buffer_used_event, frame_received_event, octet_store;
   logic [3:0] desc_index, exp_idx = 4'h0;
   hrxds_pkg::hrxds_wb_type wb, q_wb [$];
   logic [1:0] q_ev [$];
   integer seed = 18;
   int fail_count = 0, check_count = 0, stores = 0, n;
   hrxds_status #(.BUF_BYTES(BUF)) dut (.ref_clk(ref_clk), .reset(reset), .hdlc_mode(hdlc_mode),
      .max_frame_length(max_frame_length), .octet(octet), .octet_valid(octet_valid),
      .octet_ready(octet_ready), .desc_rd(desc_rd), .desc_valid(desc_valid),
      .desc_index(desc_index), .wb(wb), .wb_valid(wb_valid), .buffer_used_event(buffer_used_event),
      .frame_received_event(frame_received_event), .octet_store(octet_store));
   hrxds_host_model host (.ref_clk(ref_clk), .reset(reset), .stall(stall), .desc_index(desc_index),
      .wb(wb), .wb_valid(wb_valid), .desc_rd(desc_rd), .desc_valid(desc_valid));
   // Clock and random memory slowness
   always #5 ref_clk = ~ref_clk;
   always @(negedge ref_clk) stall <= stall_en && (($random(seed) & 3) == 0);
   // Collect every write-back with its events, and count kept octets
   always @(negedge ref_clk) begin
      if (wb_valid === 1'b1) begin
         q_wb.push_back(wb);
         q_ev.push_back({buffer_used_event, frame_received_event});
      end
      if (octet_store === 1'b1) stores++;
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic timeout;
      fail_count++;
      $display("wait bound used up at %0t", $time);
      final_report();
   endtask
   task automatic chk_word(input hrxds_pkg::hrxds_wb_type e, input hrxds_pkg::hrxds_wb_type g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch at %0t exp %h got %h", $time, e, g);
      end
   endtask
   task automatic chk_bits(input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch at %0t exp %h got %h", $time, e, g);
      end
   endtask
   // Offer one octet and hold it until the buffer takes it
   task automatic send(input logic s, input logic e, input logic [1:0] err);
      int k;
      octet = {8'($random(seed)), s, e, e && err == 2'd1, e && err == 2'd2, e && err == 2'd3};
      octet_valid = 1'b1;
      for (k = 0; k < 300 && octet_ready !== 1'b1; k++) @(negedge ref_clk);
      if (k == 300) timeout();
      @(negedge ref_clk);
   endtask
   // Arm the ring, stream one frame, then check every closed descriptor
   task automatic run_frame(input int n, input logic h, input logic cm, input logic ir,
                            input logic [1:0] err, input logic [15:0] lim, input logic hold);
      logic [31:0] d [4];
      int r, kept, nb, k;
      logic last;
      hrxds_pkg::hrxds_wb_type e;
      r = (int'(lim) + 3) / 4 * 4;
      kept = (h && n > r) ? r : n;
      nb = h ? (kept + BUF - 1) / BUF : n / BUF;
      hdlc_mode = h;
      max_frame_length = lim;
      stores = 0;
      for (k = 0; k < 4; k++) begin
         d[k] = $random(seed);
         d[k][0] = !(hold && k == int'(exp_idx));
         d[k][2] = (k == 3);
         d[k][3] = ir;
         d[k][6] = cm;
         host.arm(k, d[k]);
      end
      for (k = 0; k < n; k++) begin
         send(k == 0 && h, k == n - 1 && h, err);
         if (hold && k == 1) begin
            repeat (20) @(negedge ref_clk);
            chk_bits(16'h0, 16'(stores + q_wb.size()));
            d[exp_idx][0] = 1'b1;
            host.arm(int'(exp_idx), d[exp_idx]);
         end
      end
      octet_valid = 1'b0;
      for (k = 0; k < 400 && q_wb.size() < nb; k++) @(negedge ref_clk);
      if (k == 400) timeout();
      repeat (4) @(negedge ref_clk);
      chk_bits(16'(nb), 16'(q_wb.size()));
      chk_bits(16'(kept), 16'(stores));
      for (k = 0; k < nb; k++) begin
         last = h && k == nb - 1;
         e.index = exp_idx;
         e.word = d[exp_idx] & {16'h0, hrxds_pkg::STATUS_KEEP};
         e.word[hrxds_pkg::BIT_EMPTY] = cm;
         e.word[hrxds_pkg::BIT_FIRST] = h && k == 0;
         e.word[hrxds_pkg::BIT_LAST] = last;
         e.word[hrxds_pkg::BIT_OVERSIZE] = last && n > r;
         if (last && err != 2'd0) e.word[ERRB[err]] = 1'b1;
         e.word[31:16] = last ? 16'(n) : 16'(BUF);
         chk_word(e, q_wb.pop_front());
         chk_bits({14'h0, ir, last}, {14'h0, q_ev.pop_front()});
         exp_idx = (exp_idx == 4'h3) ? 4'h0 : exp_idx + 4'h1;
      end
      $display("frame of %0d octets done, hdlc %0d cont %0d", n, h, cm);
   endtask
   // Corner cases first, then random frames with a slow memory
   initial begin
      repeat (4) @(negedge ref_clk);
      reset = 1'b0;
      run_frame(12, 1'b1, 1'b0, 1'b1, 2'd0, 16'h0100, 1'b0);
      run_frame(5, 1'b1, 1'b0, 1'b0, 2'd0, 16'h0100, 1'b0);
      run_frame(16, 1'b1, 1'b0, 1'b1, 2'd0, 16'h0100, 1'b0);
      run_frame(26, 1'b1, 1'b0, 1'b1, 2'd0, 16'h0012, 1'b0);
      for (int i = 1; i < 4; i++) run_frame(9, 1'b1, 1'b1, 1'b1, 2'(i), 16'h0100, 1'b0);
      run_frame(16, 1'b0, 1'b0, 1'b1, 2'd0, 16'h0004, 1'b0);
      run_frame(48, 1'b0, 1'b1, 1'b0, 2'd0, 16'h0100, 1'b0);
      run_frame(6, 1'b1, 1'b0, 1'b1, 2'd0, 16'h0100, 1'b1);
      stall_en = 1'b1;
      for (int i = 0; i < 8; i++) begin
         n = 1 + ($random(seed) & 31);
         run_frame(n, 1'b1, 1'($random(seed)), 1'($random(seed)), 2'd0, 16'h0100, 1'b0);
      end
      final_report();
   end
endmodule // test_hrxds_status
